// ---- shared/spc_pkg.sv ----
`default_nettype none
package spc_pkg;
    localparam int NUM_DOMAINS = 4;
    localparam int TOP_DOMAIN  = 3;
    localparam int PRIO_W      = 5;
    localparam int NUM_PRIO    = 32;
    localparam int RUN_W       = 6;
    localparam int DOM_W       = 2;
    localparam int ADDR_W      = 8;

    // running priority when nothing is active: below every real priority
    localparam logic [RUN_W-1:0]  IDLE_RUN = 6'h20;

    // register byte offsets
    localparam logic [ADDR_W-1:0] ACTIVE_BASE    = 8'h00;
    localparam logic [ADDR_W-1:0] PRIO_MASK_BASE = 8'h10;
    localparam logic [ADDR_W-1:0] CURRENT_DOMAIN = 8'h20;
    localparam logic [ADDR_W-1:0] RUNNING_READ   = 8'h24;
    localparam logic [ADDR_W-1:0] PENDING_SUMM   = 8'h28;
    localparam logic [ADDR_W-1:0] INT_STATUS     = 8'h2c;
    localparam logic [ADDR_W-1:0] INT_MASK       = 8'h30;

    // reset values
    localparam logic [NUM_PRIO-1:0]    ACTIVE_RST   = 32'h0;
    localparam logic [PRIO_W-1:0]      PRIO_MASK_RST = 5'h1f;
    localparam logic [DOM_W-1:0]       DOMAIN_RST   = 2'h3;
    localparam logic [NUM_DOMAINS-1:0] INT_MASK_RST = 4'h0;
endpackage
`default_nettype wire

// ---- shared/prio_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface prio_if;
    logic [spc_pkg::NUM_PRIO-1:0] activeBits;
    logic [spc_pkg::PRIO_W-1:0]   prioMask;
    logic                         pendValid;
    logic [spc_pkg::PRIO_W-1:0]   pendPrio;
    logic [spc_pkg::RUN_W-1:0]    runPrio;
    logic                         qualifies;

    modport check (input activeBits, prioMask, pendValid, pendPrio,
                   output runPrio, qualifies);
    modport owner (output activeBits, prioMask, pendValid, pendPrio,
                   input runPrio, qualifies);
endinterface
`default_nettype wire

// ---- logic/domain_prio_check.sv ----
`timescale 1ns/1ps
`default_nettype none
module domain_prio_check (
    // clock and reset, assertions only
    input wire logic clock,
    input wire logic rst_n,
    // one domain's state and verdict
    prio_if.check    dom
);
    always_comb begin
        dom.runPrio = spc_pkg::IDLE_RUN;
        // lowest set index is the highest active priority
        for (int i = spc_pkg::NUM_PRIO - 1; i >= 0; i--) begin
            if (dom.activeBits[i]) begin
                dom.runPrio = spc_pkg::RUN_W'(i);
            end
        end
        dom.qualifies = dom.pendValid
                     && ({1'b0, dom.pendPrio} < dom.runPrio)
                     && (dom.pendPrio <= dom.prioMask);
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_above_running;
        dom.qualifies |-> ({1'b0, dom.pendPrio} < dom.runPrio);
    endproperty
    a_above_running: assert property (p_above_running)
        else $error("qualifying interrupt not above running priority");

    property p_within_mask;
        dom.qualifies |-> (dom.pendPrio <= dom.prioMask);
    endproperty
    a_within_mask: assert property (p_within_mask)
        else $error("qualifying interrupt outside priority mask");

    property p_both_hold;
        (dom.pendValid && ({1'b0, dom.pendPrio} < dom.runPrio)
            && (dom.pendPrio <= dom.prioMask)) |-> dom.qualifies;
    endproperty
    a_both_hold: assert property (p_both_hold)
        else $error("interrupt meeting both conditions not qualifying");

    property p_idle_run;
        (dom.activeBits == '0) |-> (dom.runPrio == spc_pkg::IDLE_RUN);
    endproperty
    a_idle_run: assert property (p_idle_run)
        else $error("idle domain without idle running priority");

    property p_highest_active;
        (dom.runPrio != spc_pkg::IDLE_RUN) |-> (dom.activeBits[dom.runPrio[4:0]]
            && ((dom.activeBits & ~({32{1'b1}} << dom.runPrio[4:0])) == 32'h0));
    endproperty
    a_highest_active: assert property (p_highest_active)
        else $error("running priority is not highest active priority");
endmodule
`default_nettype wire

// ---- logic/sufficient_priority_check.sv ----
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - qualify only above domain running priority
// - qualify only at or above priority mask
// - every domain checked with own running priority
// - readout shows current domain running priority only
// - privileged summary of qualifying pending per domain (code: domains 0 to 2 only, domain 3 not reported)
// - both conditions must hold together
// - lower domains: highest active banked priority
// - top domain: highest active dedicated priority
module sufficient_priority_check (
    // clock and reset
    input  wire logic                                              clock,
    input  wire logic                                              rst_n,
    // apb slave
    input  wire logic                                              psel,
    input  wire logic                                              penable,
    input  wire logic                                              pwrite,
    input  wire logic [spc_pkg::ADDR_W-1:0]                        paddr,
    input  wire logic [31:0]                                       pwdata,
    input  wire logic [2:0]                                        pprot,
    output logic      [31:0]                                       prdata,
    output logic                                                   pready,
    output logic                                                   pslverr,
    // pending interrupts from the controller
    input  wire logic [spc_pkg::NUM_DOMAINS-1:0]                   pendValid,
    input  wire logic [spc_pkg::NUM_DOMAINS-1:0][spc_pkg::PRIO_W-1:0] pendPrio,
    // verdicts to the core
    output logic      [spc_pkg::NUM_DOMAINS-1:0]                   sufficient,
    output logic                                                   irq
);
    localparam int ND = spc_pkg::NUM_DOMAINS;

    logic [ND-1:0][spc_pkg::NUM_PRIO-1:0] activeBits, next_activeBits;
    logic [ND-1:0][spc_pkg::PRIO_W-1:0]   prioMask, next_prioMask;
    logic [spc_pkg::DOM_W-1:0]            curDom, next_curDom;
    logic [ND-1:0]                        status, next_status;
    logic [ND-1:0]                        intMask, next_intMask;
    logic [ND-1:0]                        next_sufficient;
    logic [31:0]                          next_prdata;
    logic                                 next_pready, next_pslverr, next_irq;
    logic [ND-1:0][spc_pkg::RUN_W-1:0]    runNow;
    logic [ND-1:0]                        qualNow;
    logic                                 setup, access;
    logic [1:0]                           idx;

    assign setup  = psel && !penable;
    assign access = psel && penable && pready;
    assign idx    = paddr[3:2];

    // one checker per domain, each on its own running priority
    genvar d;
    generate
        for (d = 0; d < ND; d++) begin : g_dom
            prio_if link ();
            assign link.activeBits = activeBits[d];
            assign link.prioMask   = prioMask[d];
            assign link.pendValid  = pendValid[d];
            assign link.pendPrio   = pendPrio[d];
            assign runNow[d]       = link.runPrio;
            assign qualNow[d]      = link.qualifies;
            domain_prio_check u_check (
                .clock (clock),
                .rst_n (rst_n),
                .dom   (link)
            );
        end
    endgenerate

    // register bus: data and answer captured in setup, answered next cycle
    always_comb begin
        next_pready  = setup;
        next_prdata  = prdata;
        next_pslverr = pslverr;
        if (setup) begin
            next_prdata  = 32'h0;
            next_pslverr = 1'b0;
            if (paddr[1:0] != 2'h0) begin
                next_pslverr = 1'b1;
            end else if (paddr < spc_pkg::PRIO_MASK_BASE) begin
                next_prdata = activeBits[idx];
            end else if (paddr < spc_pkg::CURRENT_DOMAIN) begin
                next_prdata = {27'h0, prioMask[idx]};
            end else if (paddr == spc_pkg::CURRENT_DOMAIN) begin
                next_prdata = {30'h0, curDom};
            end else if (paddr == spc_pkg::RUNNING_READ) begin
                next_prdata  = {26'h0, runNow[curDom]};
                next_pslverr = pwrite;
            end else if (paddr == spc_pkg::PENDING_SUMM) begin
                next_prdata  = {29'h0, qualNow[2:0]};
                next_pslverr = pwrite || !pprot[0];
                if (!pprot[0]) begin
                    next_prdata = 32'h0;
                end
            end else if (paddr == spc_pkg::INT_STATUS) begin
                next_prdata  = {28'h0, status};
                next_pslverr = pwrite;
            end else if (paddr == spc_pkg::INT_MASK) begin
                next_prdata = {28'h0, intMask};
            end else begin
                next_pslverr = 1'b1;
            end
            if (pwrite) begin
                next_prdata = 32'h0;
            end
        end
    end

    // software state, status and interrupt line
    always_comb begin
        next_activeBits = activeBits;
        next_prioMask   = prioMask;
        next_curDom     = curDom;
        next_intMask    = intMask;
        next_status     = status;
        if (access && pwrite && !pslverr) begin
            if (paddr < spc_pkg::PRIO_MASK_BASE) begin
                next_activeBits[idx] = pwdata;
            end else if (paddr < spc_pkg::CURRENT_DOMAIN) begin
                next_prioMask[idx] = pwdata[spc_pkg::PRIO_W-1:0];
            end else if (paddr == spc_pkg::CURRENT_DOMAIN) begin
                next_curDom = pwdata[spc_pkg::DOM_W-1:0];
            end else if (paddr == spc_pkg::INT_MASK) begin
                next_intMask = pwdata[ND-1:0];
            end
        end
        // read clears only the bits it reported; a new rise wins
        if (access && !pwrite && !pslverr && paddr == spc_pkg::INT_STATUS) begin
            next_status = status & ~prdata[ND-1:0];
        end
        next_status     = next_status | (qualNow & ~sufficient);
        next_sufficient = qualNow;
        next_irq        = |(next_status & next_intMask);
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            activeBits <= {ND{spc_pkg::ACTIVE_RST}};
            prioMask   <= {ND{spc_pkg::PRIO_MASK_RST}};
            curDom     <= spc_pkg::DOMAIN_RST;
            intMask    <= spc_pkg::INT_MASK_RST;
            status     <= '0;
            sufficient <= '0;
            irq        <= 1'b0;
            prdata     <= 32'h0;
            pready     <= 1'b0;
            pslverr    <= 1'b0;
        end else begin
            activeBits <= next_activeBits;
            prioMask   <= next_prioMask;
            curDom     <= next_curDom;
            intMask    <= next_intMask;
            status     <= next_status;
            sufficient <= next_sufficient;
            irq        <= next_irq;
            prdata     <= next_prdata;
            pready     <= next_pready;
            pslverr    <= next_pslverr;
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_ready_pulse;
        setup |=> pready ##1 !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("pready not a single cycle after setup");

    property p_running_readout;
        (access && !pwrite && !pslverr && paddr == spc_pkg::RUNNING_READ)
            |-> (prdata == {26'h0, runNow[curDom]});
    endproperty
    a_running_readout: assert property (p_running_readout)
        else $error("readout not current domain running priority");

    property p_summary_value;
        (access && !pwrite && !pslverr && paddr == spc_pkg::PENDING_SUMM)
            |-> (prdata == {29'h0, $past(qualNow[2:0])});
    endproperty
    a_summary_value: assert property (p_summary_value)
        else $error("summary does not match qualifying domains");

    property p_summary_priv;
        (setup && paddr == spc_pkg::PENDING_SUMM && !pprot[0]) |=> pslverr && prdata == 32'h0;
    endproperty
    a_summary_priv: assert property (p_summary_priv)
        else $error("unprivileged summary access not refused");

    property p_status_sets;
        ((qualNow & ~sufficient) != '0)
            |=> ((status & $past(qualNow & ~sufficient)) == $past(qualNow & ~sufficient));
    endproperty
    a_status_sets: assert property (p_status_sets)
        else $error("new qualifying interrupt lost from status");

    property p_irq_level;
        ##1 (irq == |(status & intMask));
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt line disagrees with masked status");

    property p_refused_keeps;
        (access && pslverr) |=> ($stable(activeBits) && $stable(prioMask)
            && $stable(curDom) && $stable(intMask));
    endproperty
    a_refused_keeps: assert property (p_refused_keeps)
        else $error("refused transfer changed register state");

    property p_readonly_refused;
        (setup && pwrite && (paddr == spc_pkg::RUNNING_READ || paddr == spc_pkg::PENDING_SUMM
            || paddr == spc_pkg::INT_STATUS)) |=> (pready && pslverr);
    endproperty
    a_readonly_refused: assert property (p_readonly_refused)
        else $error("write to read-only register not refused");

    property p_idle_readout;
        (access && !pwrite && !pslverr && paddr == spc_pkg::RUNNING_READ
            && activeBits[curDom] == '0) |-> (prdata == {26'h0, spc_pkg::IDLE_RUN});
    endproperty
    a_idle_readout: assert property (p_idle_readout)
        else $error("idle domain readout not idle value");

    property p_status_clears;
        (access && !pwrite && !pslverr && paddr == spc_pkg::INT_STATUS
            && (qualNow & ~sufficient) == '0) |=> ((status & $past(prdata[ND-1:0])) == '0);
    endproperty
    a_status_clears: assert property (p_status_clears)
        else $error("status read did not clear reported bits");
endmodule
`default_nettype wire

// ---- dv/pend_source.sv ----
`timescale 1ns/1ps
`default_nettype none
module pend_source #(parameter int ND = 4, parameter int PW = 5) (
    // clock, reset
    input  wire logic                  clock,
    input  wire logic                  rst_n,
    // offers from the bench
    input  wire logic [ND-1:0]         offValid,
    input  wire logic [ND-1:0][PW-1:0] offPrio,
    // offers to the block, withdrawn ones never stale
    output logic      [ND-1:0]         pendValid,
    output logic      [ND-1:0][PW-1:0] pendPrio
);
    always_ff @(posedge clock) begin
        pendValid <= rst_n ? offValid : '0;
        for (int d = 0; d < ND; d++) begin
            pendPrio[d] <= (offValid[d] || !rst_n) ? offPrio[d] : ~pendPrio[d];
        end
    end
endmodule
`default_nettype wire

// ---- dv/sufficient_priority_check_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module sufficient_priority_check_tb_top;
    localparam int ND = spc_pkg::NUM_DOMAINS;
    logic               clock = 1'b0;
    logic               rst_n = 1'b0;
    logic               psel = 1'b0;
    logic               penable = 1'b0;
    logic               pwrite = 1'b0;
    logic [7:0]         paddr = 8'h00;
    logic [31:0]        pwdata = 32'h0;
    logic [2:0]         pprot = 3'h1;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic [ND-1:0]      offValid = '0;
    logic [ND-1:0][4:0] offPrio = '0;
    logic [ND-1:0]      pendValid;
    logic [ND-1:0][4:0] pendPrio;
    logic [ND-1:0]      sufficient;
    logic               irq;
    logic [31:0]        act [ND];
    logic [4:0]         msk [ND];
    int                 seed = 32'h9097;
    int                 n_mismatch = 0;
    int                 comparisons = 0;
    always #2 clock = ~clock;
    sufficient_priority_check sufficient_priority_check_i (
        .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pprot(pprot), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pendValid(pendValid), .pendPrio(pendPrio),
        .sufficient(sufficient), .irq(irq));
    pend_source #(.ND(ND), .PW(5)) pend_source_i (.clock(clock), .rst_n(rst_n),
        .offValid(offValid), .offPrio(offPrio), .pendValid(pendValid), .pendPrio(pendPrio));
    function automatic logic [5:0] run_of(input logic [31:0] a);
        run_of = spc_pkg::IDLE_RUN;
        for (int i = 31; i >= 0; i--) if (a[i]) run_of = 6'(i);
    endfunction
    function automatic logic qual_of(input int d);
        return offValid[d] && {1'b0, offPrio[d]} < run_of(act[d]) && offPrio[d] <= msk[d];
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic e);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        n = 0;
        // pready ends this wait; only the watchdog ends a hang
        while (pready !== 1'b1) begin
            n++;
            @(posedge clock);
        end
        check(32'(n), 32'h0, "wait states");
        check(32'(pready), 32'h1, "pready");
        check(32'(pslverr), 32'(e), "pslverr");
        if (!wr) check(prdata, d, "prdata");
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic tally_and_finish();
        $display("n_mismatch %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        logic [4:0] pr;
        int b;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        for (int d = 0; d < ND; d++) xfer(1'b0, spc_pkg::PRIO_MASK_BASE + 8'(4 * d), 32'h1f, 1'b0);
        xfer(1'b0, spc_pkg::RUNNING_READ, 32'h20, 1'b0);
        xfer(1'b1, spc_pkg::INT_MASK, 32'h2, 1'b0);
        offValid <= 4'h1;
        offPrio[0] <= 5'h05;
        repeat (4) @(posedge clock);
        check(32'(irq), 32'h0, "irq");
        offValid <= 4'h3;
        offPrio[1] <= 5'h1f;
        repeat (4) @(posedge clock);
        check(32'(irq), 32'h1, "irq");
        check(32'(sufficient), 32'h3, "suff");
        xfer(1'b0, spc_pkg::INT_STATUS, 32'h3, 1'b0);
        repeat (2) @(posedge clock);
        check(32'(irq), 32'h0, "irq");
        xfer(1'b0, spc_pkg::INT_STATUS, 32'h0, 1'b0);
        xfer(1'b1, spc_pkg::RUNNING_READ, 32'h5, 1'b1);
        xfer(1'b0, 8'h34, 32'h0, 1'b1);
        pprot <= 3'h0;
        xfer(1'b0, spc_pkg::PENDING_SUMM, 32'h0, 1'b1);
        pprot <= 3'h1;
        xfer(1'b0, spc_pkg::PENDING_SUMM, 32'h3, 1'b0);
        for (int it = 0; it < 150; it++) begin
            for (int d = 0; d < ND; d++) begin
                b = {$random(seed)} % 33;
                act[d] = (32'($random(seed)) << b) | (32'h1 << b);
                msk[d] = 5'($random(seed));
                pr = act[d][31] ? msk[d] + 5'(act[d][30]) : 5'(b) - 5'(act[d][30]);
                offValid[d] <= $random(seed) % 4 != 0;
                offPrio[d] <= pr;
                xfer(1'b1, spc_pkg::ACTIVE_BASE + 8'(4 * d), act[d], 1'b0);
                xfer(1'b1, spc_pkg::PRIO_MASK_BASE + 8'(4 * d), 32'(msk[d]), 1'b0);
            end
            repeat (3) @(posedge clock);
            for (int d = 0; d < ND; d++) begin
                check(32'(sufficient[d]), 32'(qual_of(d)), "suff");
            end
            b = {$random(seed)} % ND;
            xfer(1'b1, spc_pkg::CURRENT_DOMAIN, 32'(b), 1'b0);
            xfer(1'b0, spc_pkg::RUNNING_READ, 32'(run_of(act[b])), 1'b0);
            b = 32'({qual_of(2), qual_of(1), qual_of(0)});
            xfer(1'b0, spc_pkg::PENDING_SUMM, 32'(b), 1'b0);
        end
        // second reset in mid-run: outputs cleared, registers back to reset values
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        check(32'(sufficient), 32'h0, "reset suff");
        check(32'(irq), 32'h0, "reset irq");
        check(prdata, 32'h0, "reset prdata");
        check(32'({pready, pslverr}), 32'h0, "reset ready");
        rst_n <= 1'b1;
        @(posedge clock);
        xfer(1'b0, spc_pkg::CURRENT_DOMAIN, 32'h3, 1'b0);
        xfer(1'b0, spc_pkg::INT_MASK, 32'h0, 1'b0);
        xfer(1'b0, spc_pkg::PRIO_MASK_BASE + 8'h0c, 32'h1f, 1'b0);
        xfer(1'b0, spc_pkg::ACTIVE_BASE + 8'h08, 32'h0, 1'b0);
        xfer(1'b0, spc_pkg::RUNNING_READ, 32'h20, 1'b0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
